/* File: ae_pkg.sv */
// Constants and register layout for the automatic exposure control block
package ae_pkg;
  localparam logic [31:0] TARGET_ADDR    = 32'hF0F00804;
  localparam logic [31:0] EXPOSURE_ADDR  = 32'hF0F0081C;
  localparam logic [31:0] GAIN_ADDR      = 32'hF0F00820;
  localparam int          PRESENT_BIT    = 0;
  localparam int          ABS_BIT        = 1;
  localparam int          ONE_SHOT_BIT   = 5;
  localparam int          ON_BIT         = 6;
  localparam int          AUTO_BIT       = 7;
  localparam int          VALUE_LSB      = 20;
  localparam int          VALUE_W        = 12;
  localparam logic [11:0] TARGET_MIN     = 12'h032;
  localparam logic [11:0] TARGET_MAX     = 12'h0CD;
  localparam logic [11:0] TARGET_RESET   = 12'h080;
  localparam logic [11:0] EXP_RESET      = 12'h100;
  localparam logic [11:0] GAIN_RESET     = 12'h000;
  localparam logic [11:0] EXP_MIN_DEF    = 12'h001;
  localparam logic [11:0] EXP_MAX_DEF    = 12'hFFF;
  localparam logic [11:0] GAIN_MIN_DEF   = 12'h000;
  localparam logic [11:0] GAIN_MAX_DEF   = 12'h2A8;
  localparam int          KP_SHIFT       = 2;
  localparam int          KI_SHIFT       = 4;
  localparam int          SETTLE_TOL     = 1;
  localparam int          SHOT_STEPS     = 16;
endpackage

/* File: pi_step.sv */
// One proportional plus integral update of a bounded 12-bit actuator
`timescale 1ns/1ps
`default_nettype none
module pi_step
  import ae_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        clear_i,
  input  wire logic [11:0] target_i,
  input  wire logic [11:0] measured_i,
  input  wire logic [11:0] current_i,
  input  wire logic [11:0] lo_i,
  input  wire logic [11:0] hi_i,
  output logic      [11:0] next_o,
  output logic             settled_o
);
  logic signed [13:0] err;
  logic signed [19:0] integ_q;
  logic signed [19:0] integ_d;
  logic signed [20:0] step;
  logic signed [20:0] cand;
  logic               sat;
  always_comb begin
    err = $signed({2'b00, target_i}) - $signed({2'b00, measured_i});
    integ_d = integ_q + 20'(err);
    step = 21'(err >>> KP_SHIFT) + 21'(integ_d >>> KI_SHIFT);
    // No overshoot: never move further than the error itself
    if (err >= 0 && step > 21'(err)) step = 21'(err);
    if (err < 0 && step < 21'(err)) step = 21'(err);
    if (err > 0 && step < 0) step = 21'sd0;
    if (err < 0 && step > 0) step = 21'sd0;
    cand = $signed({9'b0, current_i}) + step;
    if (cand < $signed({9'b0, lo_i})) next_o = lo_i;
    else if (cand > $signed({9'b0, hi_i})) next_o = hi_i;
    else next_o = cand[11:0];
    // Clamped output: integrator must not wind up
    sat = (cand < $signed({9'b0, lo_i})) || (cand > $signed({9'b0, hi_i}));
    settled_o = (err <= 14'(SETTLE_TOL)) && (err >= -14'(SETTLE_TOL));
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) integ_q <= '0;
    else if (run_i && !settled_o && !sat) integ_q <= integ_d;
  end
endmodule
`default_nettype wire

/* File: auto_exposure_control.sv */
// Feature registers and closed-loop exposure and gain control
`timescale 1ns/1ps
`default_nettype none
module auto_exposure_control
  import ae_pkg::*;
#(
  parameter bit EXP_PRESENT  = 1'b1,
  parameter bit GAIN_PRESENT = 1'b1,
  parameter bit TGT_PRESENT  = 1'b1
)(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic             rvalid_o,
  input  wire logic        frame_i,
  input  wire logic [11:0] brightness_i,
  input  wire logic        adv_exp_en_i,
  input  wire logic [11:0] adv_exp_min_i,
  input  wire logic [11:0] adv_exp_max_i,
  input  wire logic        adv_gain_en_i,
  input  wire logic [11:0] adv_gain_min_i,
  input  wire logic [11:0] adv_gain_max_i,
  input  wire logic [11:0] abs_exp_i,
  input  wire logic [11:0] abs_gain_i,
  output logic      [11:0] exposure_o,
  output logic      [11:0] gain_o
);
  typedef enum logic [1:0] {F_EXP, F_GAIN, F_TGT} feat_type;
  logic [2:0]  abs_q, on_q, auto_q, busy_q;
  logic [11:0] exp_q, gain_q, tgt_q;
  logic [4:0]  shots_q;
  logic [2:0]  hit;
  logic [11:0] wval, exp_lo, exp_hi, gain_lo, gain_hi, exp_nx, gain_nx;
  logic        exp_set, gain_set, exp_run, gain_run;

  assign hit[F_EXP]  = addr_i == EXPOSURE_ADDR;
  assign hit[F_GAIN] = addr_i == GAIN_ADDR;
  assign hit[F_TGT]  = addr_i == TARGET_ADDR;
  assign wval = wdata_i[VALUE_LSB +: VALUE_W];

  assign exp_lo  = adv_exp_en_i ? adv_exp_min_i : EXP_MIN_DEF;
  assign exp_hi  = adv_exp_en_i ? adv_exp_max_i : EXP_MAX_DEF;
  assign gain_lo = adv_gain_en_i ? adv_gain_min_i : GAIN_MIN_DEF;
  assign gain_hi = adv_gain_en_i ? adv_gain_max_i : GAIN_MAX_DEF;

  // Loop runs per frame when on and auto or a one-shot is active; gain also needs the target on
  assign exp_run  = frame_i && on_q[F_EXP] && (auto_q[F_EXP] || busy_q[F_EXP]);
  assign gain_run = frame_i && on_q[F_GAIN] && (auto_q[F_GAIN] || busy_q[F_GAIN])
                    && on_q[F_TGT];

  pi_step u_exp (
    .clk_i      (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (exp_run),
    .clear_i    (!on_q[F_EXP]),
    .target_i   (tgt_q),
    .measured_i (brightness_i),
    .current_i  (exp_q),
    .lo_i       (exp_lo),
    .hi_i       (exp_hi),
    .next_o     (exp_nx),
    .settled_o  (exp_set)
  );
  pi_step u_gain (
    .clk_i      (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (gain_run),
    .clear_i    (!on_q[F_GAIN]),
    .target_i   (tgt_q),
    .measured_i (brightness_i),
    .current_i  (gain_q),
    .lo_i       (gain_lo),
    .hi_i       (gain_hi),
    .next_o     (gain_nx),
    .settled_o  (gain_set)
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      abs_q  <= '0;
      on_q   <= '0;
      auto_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_i && hit[i]) begin
          abs_q[i]  <= wdata_i[ABS_BIT];
          on_q[i]   <= wdata_i[ON_BIT];
          auto_q[i] <= wdata_i[AUTO_BIT];
        end
      end
    end
  end

  // Manual value writes accepted only when on and manual
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      exp_q  <= EXP_RESET;
      gain_q <= GAIN_RESET;
      tgt_q  <= TARGET_RESET;
    end else begin
      if (exp_run) exp_q <= exp_nx;
      else if (wr_i && hit[F_EXP] && on_q[F_EXP] && !auto_q[F_EXP])
        exp_q <= (wval < exp_lo) ? exp_lo : (wval > exp_hi) ? exp_hi : wval;
      if (gain_run) gain_q <= gain_nx;
      else if (wr_i && hit[F_GAIN] && on_q[F_GAIN] && !auto_q[F_GAIN])
        gain_q <= (wval < gain_lo) ? gain_lo : (wval > gain_hi) ? gain_hi : wval;
      if (wr_i && hit[F_TGT] && on_q[F_TGT] && !auto_q[F_TGT])
        tgt_q <= (wval < TARGET_MIN) ? TARGET_MIN :
                 (wval > TARGET_MAX) ? TARGET_MAX : wval;
    end
  end

  // One-shot: exposure busy until settled or step budget spent, gain until settled, target while gain busy
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_q  <= '0;
      shots_q <= '0;
    end else begin
      if (wr_i && hit[F_EXP] && wdata_i[ONE_SHOT_BIT] && !auto_q[F_EXP]
          && !wdata_i[AUTO_BIT]) begin
        busy_q[F_EXP] <= 1'b1;
        shots_q <= '0;
      end else if (busy_q[F_EXP] && (!on_q[F_EXP] || (exp_run &&
                   (exp_set || shots_q == 5'(SHOT_STEPS - 1))))) begin
        busy_q[F_EXP] <= 1'b0;
      end else if (exp_run) begin
        shots_q <= shots_q + 5'd1;
      end
      if (wr_i && hit[F_GAIN] && wdata_i[ONE_SHOT_BIT]) busy_q[F_GAIN] <= 1'b1;
      else if (busy_q[F_GAIN] && (!on_q[F_GAIN] || !on_q[F_TGT] || (gain_run && gain_set)))
        busy_q[F_GAIN] <= 1'b0;
      if (wr_i && hit[F_TGT] && wdata_i[ONE_SHOT_BIT]) busy_q[F_TGT] <= 1'b1;
      else if (busy_q[F_TGT] && !busy_q[F_GAIN]) busy_q[F_TGT] <= 1'b0;
    end
  end

  // Readback, reserved bits zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      rdata_o  <= '0;
      for (int i = 0; i < 3; i++) begin
        if (rd_i && hit[i]) begin
          rdata_o[PRESENT_BIT]  <= (i == F_EXP) ? EXP_PRESENT :
                                   (i == F_GAIN) ? GAIN_PRESENT : TGT_PRESENT;
          rdata_o[ABS_BIT]      <= abs_q[i];
          rdata_o[ONE_SHOT_BIT] <= busy_q[i];
          rdata_o[ON_BIT]       <= on_q[i];
          rdata_o[AUTO_BIT]     <= auto_q[i];
          rdata_o[VALUE_LSB +: VALUE_W] <= (i == F_EXP) ? exp_q :
                                           (i == F_GAIN) ? gain_q : tgt_q;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      exposure_o <= EXP_RESET;
      gain_o     <= GAIN_RESET;
    end else begin
      exposure_o <= abs_q[F_EXP] ? abs_exp_i : exp_q;
      gain_o     <= abs_q[F_GAIN] ? abs_gain_i : gain_q;
    end
  end
endmodule
`default_nettype wire

/* File: ae_monitor.sv */
// Port checker for the auto exposure control block
`timescale 1ns/1ps
`default_nettype none
module ae_monitor
  import ae_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic [11:0] exposure_o,
  input wire logic [11:0] gain_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_ans; rd_i |=> rvalid_o; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_quiet; !rd_i |=> !rvalid_o; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious read valid");
  property p_idle; !rvalid_o |-> rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_rsv; rvalid_o |-> rdata_o[4:2] == 3'h0 && rdata_o[19:8] == 12'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_pres;
    rd_i && (addr_i == TARGET_ADDR || addr_i == EXPOSURE_ADDR || addr_i == GAIN_ADDR)
      |=> rdata_o[PRESENT_BIT];
  endproperty
  a_pres: assert property (p_pres) else $error("presence bit low");
  property p_tgt;
    rd_i && addr_i == TARGET_ADDR |=> rdata_o[31:20] >= TARGET_MIN && rdata_o[31:20] <= TARGET_MAX;
  endproperty
  a_tgt: assert property (p_tgt) else $error("target out of range");
  property p_gmax; gain_o <= GAIN_MAX_DEF; endproperty
  a_gmax: assert property (p_gmax) else $error("gain above limit");
  property p_emin; exposure_o >= EXP_MIN_DEF; endproperty
  a_emin: assert property (p_emin) else $error("exposure below limit");
endmodule
bind auto_exposure_control ae_monitor u_ae_monitor (.core_clk_i, .rst_i, .addr_i, .rd_i,
  .rdata_o, .rvalid_o, .exposure_o, .gain_o);
`default_nettype wire

/* File: auto_exposure_control_tb.sv */
// Register and loop tests for the auto exposure control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module auto_exposure_control_tb;
  import ae_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i, wr_i, rd_i, rvalid_o, frame_i, adv_gain_en_i;
  logic [31:0] addr_i, wdata_i, rdata_o;
  logic [11:0] brightness_i, abs_gain_i, abs_exp_i, exposure_o, gain_o;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #2 core_clk_i = ~core_clk_i;
  auto_exposure_control u_auto_exposure_control (.core_clk_i, .rst_i, .addr_i, .wr_i,
    .rd_i, .wdata_i, .rdata_o, .rvalid_o, .frame_i, .brightness_i, .adv_exp_en_i(1'b0),
    .adv_exp_min_i(12'h001), .adv_exp_max_i(12'hFFF), .adv_gain_en_i,
    .adv_gain_min_i(12'h010), .adv_gain_max_i(12'h020), .abs_exp_i,
    .abs_gain_i, .exposure_o, .gain_o);
  task automatic cyc;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    cyc();
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    cyc();
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    cyc();
    addr_i = a;
    rd_i = 1'b1;
    cyc();
    rd_i = 1'b0;
    `CHK(rvalid_o, 1'b1)
    `CHK(rdata_o & m, e & m)
  endtask
  task automatic frm(input logic [11:0] b, input int n);
    repeat (n) begin
      cyc();
      brightness_i = b;
      frame_i = 1'b1;
      cyc();
      frame_i = 1'b0;
      repeat (4) cyc();
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_i, wr_i, rd_i, frame_i, adv_gain_en_i} = 5'h10;
    {addr_i, wdata_i, brightness_i} = '0;
    abs_gain_i = 12'h055;
    abs_exp_i = 12'h200;
    repeat (6) cyc();
    rst_i = 1'b0;
    rd(TARGET_ADDR, 32'h08000001);
    rd(EXPOSURE_ADDR, 32'h10000001);
    rd(GAIN_ADDR, 32'h00000001);
    rd(32'hF0F00808, 32'h00000000);
    wr(GAIN_ADDR, 32'h12300000);
    rd(GAIN_ADDR, 32'h00000001);
    wr(GAIN_ADDR, 32'h123FFF5C);
    wr(GAIN_ADDR, 32'h123FFF5C);
    rd(GAIN_ADDR, 32'h12300041);
    `CHK(gain_o, 12'h123)
    wr(GAIN_ADDR, 32'h12300042);
    cyc();
    `CHK(gain_o, 12'h055)
    wr(GAIN_ADDR, 32'h01000040);
    wr(GAIN_ADDR, 32'h010000C0);
    wr(GAIN_ADDR, 32'h777000C0);
    rd(GAIN_ADDR, 32'h010000C1);
    wr(TARGET_ADDR, 32'h00000040);
    wr(TARGET_ADDR, 32'h01400040);
    rd(TARGET_ADDR, 32'h03200041);
    wr(TARGET_ADDR, 32'h0FF00040);
    rd(TARGET_ADDR, 32'h0CD00041);
    wr(TARGET_ADDR, 32'h08000040);
    adv_gain_en_i = 1'b1;
    frm(12'h010, 20);
    `CHK(gain_o, 12'h020)
    frm(12'h0F0, 20);
    `CHK(gain_o, 12'h010)
    wr(EXPOSURE_ADDR, 32'h00000060);
    rd(EXPOSURE_ADDR, 32'h00000061, 32'h000000FF);
    frm(12'h080, 16);
    rd(EXPOSURE_ADDR, 32'h00000041, 32'h000000FF);
    wr(EXPOSURE_ADDR, 32'h000000E0);
    rd(EXPOSURE_ADDR, 32'h000000C1, 32'h000000FF);
    wr(GAIN_ADDR, 32'h00000040);
    wr(GAIN_ADDR, 32'h00000060);
    rd(GAIN_ADDR, 32'h00000061, 32'h000000FF);
    frm(12'h080, 16);
    rd(GAIN_ADDR, 32'h00000041, 32'h000000FF);
    // One-shot that never settles ends after the step budget
    wr(EXPOSURE_ADDR, 32'h00000040);
    wr(EXPOSURE_ADDR, 32'h00000060);
    frm(12'h070, 15);
    rd(EXPOSURE_ADDR, 32'h00000061, 32'h000000FF);
    `CHK(exposure_o > 12'h001, 1'b1)
    frm(12'h070, 1);
    rd(EXPOSURE_ADDR, 32'h00000041, 32'h000000FF);
    // Target busy follows the gain adjustment
    wr(GAIN_ADDR, 32'h00000060);
    wr(TARGET_ADDR, 32'h08000060);
    rd(TARGET_ADDR, 32'h00000061, 32'h000000FF);
    frm(12'h080, 1);
    rd(TARGET_ADDR, 32'h00000041, 32'h000000FF);
    // Target switched off: auto gain must hold still
    wr(TARGET_ADDR, 32'h08000000);
    wr(GAIN_ADDR, 32'h000000C0);
    frm(12'h010, 2);
    `CHK(gain_o, 12'h010)
    wr(EXPOSURE_ADDR, 32'h00000042);
    cyc();
    `CHK(exposure_o, 12'h200)
    // Reset in mid-run restores defaults
    rst_i = 1'b1;
    repeat (2) cyc();
    rst_i = 1'b0;
    rd(EXPOSURE_ADDR, 32'h10000001);
    `CHK(exposure_o, 12'h100)
    end_of_test();
  end
endmodule
`default_nettype wire
